//--- src/msc_pkg.sv
/*
   Shared constants, types and decode helpers for the multiplexed SAR converter control.
   Assumes a 20 MHz system clock; every timing count below is derived from it.
*/
package msc_pkg;

   localparam int CODE_W       = 16;
   localparam int CFG_W        = 8;
   localparam int REC_W        = CODE_W + CFG_W;
   localparam int FIFO_DEPTH   = 32;
   localparam int CLK_NS       = 50;
   // Bit decision time of the internal oscillator; a least time, rounded up
   localparam int BIT_STEP_NS  = 100;
   localparam int BIT_STEP_CYC = (BIT_STEP_NS + CLK_NS - 1) / CLK_NS;
   // Summing node discharge; a longest time, rounded down but never below one cycle
   localparam int MRST_NS      = 36;
   localparam int MRST_CYC     = (MRST_NS / CLK_NS < 1) ? 1 : MRST_NS / CLK_NS;

   // Configuration word layout
   localparam int CFG_VALID_BIT = 7;
   localparam int CFG_GAIN_BIT  = 6;
   localparam int CFG_RANGE_LSB = 4;
   localparam int CFG_CHAN_LSB  = 0;

   localparam logic [CFG_W-1:0]  CFG_RESET  = 8'h00;
   localparam logic [CODE_W-1:0] CODE_MSB   = 16'h8000;
   localparam logic [4:0]        SEQ_FULL   = 5'h10;
   localparam logic [4:0]        DEPTH_INIT = 5'h01;
   localparam logic [2:0]        WORD_LAST  = 3'h7;
   localparam logic [2:0]        MRST_LOAD  = 3'(MRST_CYC);

   typedef enum logic [1:0] {RNG_UNIPOLAR, RNG_BIPOLAR, RNG_DIFF_BIN, RNG_DIFF_TWOS} msc_range_t;

   // Two's complement for bipolar, selectable for fully differential
   function automatic logic fmtTwos(input logic [CFG_W-1:0] w);
      msc_range_t r;
      r = msc_range_t'(w[CFG_RANGE_LSB +: 2]);
      return (r == RNG_BIPOLAR) || (r == RNG_DIFF_TWOS);
   endfunction

endpackage

//--- src/msc_stream_if.sv
/*
   Valid/ready word stream between the converter core, the result FIFO and the serial port.
   Assumes both ends share one clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface msc_stream_if #(parameter int W = 24);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- src/msc_fifo.sv
/*
   Result FIFO, parameterised in width and depth, valid/ready on both sides.
   Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module msc_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   input  wire logic   mclk,
   input  wire logic   rst,
   msc_stream_if.snk   wr,
   msc_stream_if.src   rd
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] memQ [DEPTH];
   logic [AW:0]      wrPtrQ, wrPtrD, rdPtrQ, rdPtrD;
   logic             full, empty, push, pop;

   assign full     = (wrPtrQ[AW-1:0] == rdPtrQ[AW-1:0]) && (wrPtrQ[AW] != rdPtrQ[AW]);
   assign empty    = (wrPtrQ == rdPtrQ);
   assign wr.ready = ~full;
   assign rd.valid = ~empty;
   assign rd.data  = memQ[rdPtrQ[AW-1:0]];
   assign push     = wr.valid & ~full;
   assign pop      = rd.ready & ~empty;

   always_comb begin
      wrPtrD = push ? wrPtrQ + 1'b1 : wrPtrQ;
      rdPtrD = pop ? rdPtrQ + 1'b1 : rdPtrQ;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrPtrQ <= '0;
         rdPtrQ <= '0;
      end else begin
         wrPtrQ <= wrPtrD;
         rdPtrQ <= rdPtrD;
      end
   end

   // Storage carries no reset; only the pointers need a defined value
   always_ff @(posedge mclk) begin
      if (push) begin
         memQ[wrPtrQ[AW-1:0]] <= wr.data;
      end
   end
endmodule
`default_nettype wire

//--- src/msc_sar.sv
/*
   Successive-approximation sequencer driving the sampling capacitor DAC.
   Assumes a comparator decision on compIn, synchronous to mclk, valid at each step's last cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module msc_sar import msc_pkg::*; (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              start,
   input  wire logic              compIn,
   input  wire logic [CFG_W-1:0]  cfgIn,
   output logic                   busy,
   output logic      [CODE_W-1:0] dacCode,
   msc_stream_if.src              res
);
   typedef enum logic [1:0] {SAR_IDLE, SAR_STEP, SAR_DONE} msc_sar_t;

   msc_sar_t          stateQ, stateD;
   logic [CODE_W-1:0] codeQ, codeD, maskQ, maskD;
   logic [CFG_W-1:0]  cfgQ, cfgD;
   logic [3:0]        stepQ, stepD;
   logic              stepEnd;

   assign stepEnd   = (stepQ == 4'(BIT_STEP_CYC - 1));
   assign busy      = (stateQ != SAR_IDLE);
   assign dacCode   = codeQ;
   assign res.valid = (stateQ == SAR_DONE);
   assign res.data  = {codeQ ^ (fmtTwos(cfgQ) ? CODE_MSB : {CODE_W{1'b0}}), cfgQ};

   always_comb begin
      stateD = stateQ;
      codeD  = codeQ;
      maskD  = maskQ;
      cfgD   = cfgQ;
      stepD  = stepQ;
      case (stateQ)
         SAR_IDLE: begin
            if (start) begin
               stateD = SAR_STEP;
               codeD  = CODE_MSB;
               maskD  = CODE_MSB;
               cfgD   = cfgIn;
               stepD  = '0;
            end
         end
         SAR_STEP: begin
            stepD = stepQ + 4'h1;
            if (stepEnd) begin
               // Keep or drop the trial bit, then try the next lower weight
               codeD = (compIn ? codeQ : codeQ & ~maskQ) | (maskQ >> 1);
               maskD = maskQ >> 1;
               stepD = '0;
               if (maskQ[0]) begin
                  stateD = SAR_DONE;
               end
            end
         end
         SAR_DONE: begin
            // Holds, and so stays busy, until the FIFO takes the result
            if (res.ready) begin
               stateD = SAR_IDLE;
            end
         end
         default: stateD = SAR_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stateQ <= SAR_IDLE;
         codeQ  <= '0;
         maskQ  <= '0;
         cfgQ   <= CFG_RESET;
         stepQ  <= '0;
      end else begin
         stateQ <= stateD;
         codeQ  <= codeD;
         maskQ  <= maskD;
         cfgQ   <= cfgD;
         stepQ  <= stepD;
      end
   end

   localparam int CONV_CYC = CODE_W * BIT_STEP_CYC;
   // Result shows one cycle after the last decision, counted from the end of the busy pair
   localparam int CONV_END = CONV_CYC - 1;

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   sequence sarStart;
      stateQ == SAR_IDLE && start;
   endsequence
   sequence sarRun;
      busy [*2];
   endsequence

   sar_timing_a: assert property (sarStart |=> sarRun ##[CONV_END:CONV_END] res.valid)
      else $error("conversion did not finish after sixteen bit steps");
   sar_format_a: assert property (res.valid |-> res.data[REC_W-1] == (dacCode[CODE_W-1] ^ res.data[CFG_RANGE_LSB]))
      else $error("result format does not match selected range");
endmodule
`default_nettype wire

//--- src/msc_adc_ctrl.sv
/*
   Control and serial port of an 8-channel 16-bit SAR converter: conversion start,
   busy, sequencer of configuration words, result FIFO and read-select gated shifter.
   Assumes all pins except compIn are asynchronous to mclk; serial clock well below a quarter of mclk.
*/
// Functional notes
// - Rising convert_start edge wakes from nap or sleep and starts one conversion.
// - Busy rises when a conversion starts and falls once its result has entered the FIFO.
// - Serial port active while read_select_n low; output released while high.
// - Serial clock edges are ignored while read_select_n is high.
// - Input bit captured on each rising serial clock edge while active.
// - Each rising edge shifts out result MSB first, then configuration info.
// - Shifted-in words program channel, input range and gain compression via sequencer.
// - Sequencer holds one to sixteen configuration words chosen by host.
// - Reset abandons any conversion and releases the serial output.
// - End of conversion yields a 16-bit code ready for serial transfer.
// - DAC walks a successive-approximation search, one decision per bit, 16 bits.
// - Straight binary equals two's complement with MSB inverted; range picks format.
// - Input range is independent of multiplexer channel selection.
// - Automatic nap between conversions plus a separate sleep state.
// - Bipolar gives two's complement, unipolar binary, differential selectable.
// - Summing node discharged every conversion and on first new configuration.
`timescale 1ns/100ps
`default_nettype none
module msc_adc_ctrl import msc_pkg::*; (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              convertStart,
   input  wire logic              readSelectN,
   input  wire logic              sck,
   input  wire logic              sdi,
   input  wire logic              sleepReq,
   input  wire logic              compIn,
   output logic                   sdoOut,
   output logic                   sdoOe,
   output logic                   busy,
   output logic                   napActive,
   output logic                   sleepActive,
   output logic                   muxDischarge,
   output logic                   gainCompression,
   output logic      [3:0]        muxChannel,
   output logic      [1:0]        inputRange,
   output logic      [CODE_W-1:0] dacCode
);
   // Pin synchronisers: meta, sync, then one history stage for edges
   logic [4:0] pinIn, metaQ, syncQ, histQ;
   logic       cnvS, rsnS, sckS, sdiS, slpS;
   logic       cnvEdge, sckRise, frameStart, startPulse;

   assign pinIn = {convertStart, readSelectN, sck, sdi, sleepReq};

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         metaQ <= 5'h08;
         syncQ <= 5'h08;
         histQ <= 5'h08;
      end else begin
         metaQ <= pinIn;
         syncQ <= metaQ;
         histQ <= syncQ;
      end
   end

   assign {cnvS, rsnS, sckS, sdiS, slpS} = syncQ;
   assign cnvEdge    = cnvS & ~histQ[4];
   assign startPulse = cnvEdge & ~busy;
   assign sckRise    = sckS & ~histQ[2] & ~rsnS;
   assign frameStart = ~rsnS & histQ[3];

   // Converter core and result buffering
   msc_stream_if #(.W(REC_W)) convS ();
   msc_stream_if #(.W(REC_W)) outS ();
   logic [CFG_W-1:0] curCfg;
   logic             resultTaken;

   msc_sar u_sar (
      .mclk    (mclk),
      .rst     (rst),
      .start   (startPulse),
      .compIn  (compIn),
      .cfgIn   (curCfg),
      .busy    (busy),
      .dacCode (dacCode),
      .res     (convS.src)
   );

   msc_fifo #(.WIDTH(REC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk (mclk),
      .rst  (rst),
      .wr   (convS.snk),
      .rd   (outS.src)
   );

   assign resultTaken = convS.valid & convS.ready;

   // Serial shifter
   logic [REC_W-1:0] outShiftQ, outShiftD;
   logic [CFG_W-1:0] inShiftQ, inShiftD, wordNew;
   logic [2:0]       bitCntQ, bitCntD;
   logic             oeQ, oeD, firstQ, firstD, wordDone;

   assign wordNew  = {inShiftQ[CFG_W-2:0], sdiS};
   assign wordDone = sckRise && (bitCntQ == WORD_LAST) && wordNew[CFG_VALID_BIT];
   assign outS.ready = frameStart;
   assign sdoOut     = outShiftQ[REC_W-1];
   assign sdoOe      = oeQ;

   always_comb begin
      outShiftD = outShiftQ;
      inShiftD  = inShiftQ;
      bitCntD   = bitCntQ;
      oeD       = 1'b0;
      firstD    = firstQ;
      if (rsnS) begin
         bitCntD = '0;
         firstD  = 1'b1;
      end else begin
         oeD = 1'b1;
         if (frameStart) begin
            // An empty FIFO shifts out zeros rather than a stale record
            outShiftD = outS.valid ? outS.data : '0;
         end else if (sckRise) begin
            outShiftD = {outShiftQ[REC_W-2:0], 1'b0};
            inShiftD  = wordNew;
            bitCntD   = bitCntQ + 3'h1;
            if (wordDone) begin
               firstD = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         outShiftQ <= '0;
         inShiftQ  <= '0;
         bitCntQ   <= '0;
         oeQ       <= 1'b0;
         firstQ    <= 1'b1;
      end else begin
         outShiftQ <= outShiftD;
         inShiftQ  <= inShiftD;
         bitCntQ   <= bitCntD;
         oeQ       <= oeD;
         firstQ    <= firstD;
      end
   end

   // Sequencer, discharge timer and power state
   logic [CFG_W-1:0] cfgMemQ [16];
   logic [CFG_W-1:0] cfgMemD [16];
   logic [CFG_W-1:0] cfgOutQ, cfgOutD;
   logic [4:0]       depthQ, depthD;
   logic [3:0]       seqIdxQ, seqIdxD;
   logic [2:0]       dischQ, dischD;
   logic             sleepQ, sleepD;

   // Last programmed entry reached; shared by the advance and its check
   function automatic logic lastEntry(input logic [3:0] idx, input logic [4:0] depth);
      return (5'(idx) + 5'h01 >= depth);
   endfunction

   assign curCfg = cfgMemQ[seqIdxQ];

   always_comb begin
      cfgMemD = cfgMemQ;
      depthD  = depthQ;
      seqIdxD = seqIdxQ;
      dischD  = (dischQ != '0) ? dischQ - 3'h1 : dischQ;
      if (resultTaken) begin
         seqIdxD = lastEntry(seqIdxQ, depthQ) ? 4'h0 : seqIdxQ + 4'h1;
      end
      if (startPulse) begin
         dischD = MRST_LOAD;
      end
      if (wordDone) begin
         if (firstQ) begin
            // First word of a frame restarts the list at depth one
            cfgMemD[0] = wordNew;
            depthD     = DEPTH_INIT;
            seqIdxD    = 4'h0;
            dischD     = MRST_LOAD;
         end else if (depthQ < SEQ_FULL) begin
            cfgMemD[depthQ[3:0]] = wordNew;
            depthD               = depthQ + 5'h01;
         end
      end
      cfgOutD = cfgMemD[seqIdxD];
      // Sleep holds while requested and idle; a convert edge always wakes
      sleepD = ~cnvEdge & slpS & (sleepQ | ~busy);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            cfgMemQ[i] <= CFG_RESET;
         end
         cfgOutQ <= CFG_RESET;
         depthQ  <= DEPTH_INIT;
         seqIdxQ <= '0;
         dischQ  <= '0;
         sleepQ  <= 1'b0;
      end else begin
         cfgMemQ <= cfgMemD;
         cfgOutQ <= cfgOutD;
         depthQ  <= depthD;
         seqIdxQ <= seqIdxD;
         dischQ  <= dischD;
         sleepQ  <= sleepD;
      end
   end

   // Range and channel are separate fields, any pairing allowed
   assign muxChannel      = cfgOutQ[CFG_CHAN_LSB +: 4];
   assign inputRange      = cfgOutQ[CFG_RANGE_LSB +: 2];
   assign gainCompression = cfgOutQ[CFG_GAIN_BIT];
   assign muxDischarge    = (dischQ != '0);
   assign napActive       = ~busy & ~sleepQ;
   assign sleepActive     = sleepQ;

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   start_busy_a: assert property (cnvEdge && !busy |=> busy)
      else $error("convert edge did not start a conversion");
   busy_release_a: assert property (convS.valid && convS.ready |=> !busy)
      else $error("busy stayed high after result taken");
   output_hiz_a: assert property (rsnS |=> !sdoOe)
      else $error("serial output driven while deselected");
   clock_gated_a: assert property (rsnS && !frameStart |=> $stable(outShiftQ))
      else $error("shifter moved while deselected");
   sdi_capture_a: assert property (sckRise && !frameStart |=> inShiftQ[0] == $past(sdiS))
      else $error("input bit not captured on clock edge");
   shift_out_a: assert property (sckRise && !frameStart |=> sdoOut == $past(outShiftQ[REC_W-2]))
      else $error("output not shifted MSB first");
   depth_range_a: assert property (depthQ >= DEPTH_INIT && depthQ <= SEQ_FULL)
      else $error("sequencer depth out of range");
   discharge_a: assert property (startPulse |=> muxDischarge [*1] ##1 !muxDischarge)
      else $error("summing node discharge missing at conversion start");
   seq_wrap_a: assert property (resultTaken && !wordDone && 5'(seqIdxQ) + 5'h01 == depthQ |=> seqIdxQ == 4'h0)
      else $error("sequencer did not wrap after last word");

   // Serial port framing and gating
   port_enable_a: assert property (!rsnS |=> sdoOe)
      else $error("serial output not driven while selected");
   input_gated_a: assert property (rsnS |=> $stable(inShiftQ))
      else $error("input shifter moved while deselected");
   count_clear_a: assert property (rsnS |=> bitCntQ == 3'h0)
      else $error("bit counter not cleared between frames");
   bit_step_a: assert property (sckRise && !frameStart |=> bitCntQ == $past(bitCntQ) + 3'h1)
      else $error("bit counter missed a clock edge");
   record_load_a: assert property (frameStart && outS.valid |=> outShiftQ == $past(outS.data))
      else $error("oldest record not loaded at frame start");
   empty_load_a: assert property (frameStart && !outS.valid |=> outShiftQ == '0)
      else $error("empty buffer did not load zeros");

   // Configuration list; a frame's first valid word restarts it
   sequence firstWord;
      wordDone && firstQ;
   endsequence

   sequence laterWord;
      wordDone && !firstQ;
   endsequence

   // Words past sixteen are dropped, not wrapped over the start
   first_set_a: assert property (rsnS |=> firstQ)
      else $error("frame did not rearm the list restart");
   first_word_a: assert property (firstWord |=> depthQ == DEPTH_INIT && cfgMemQ[0] == $past(wordNew))
      else $error("first word did not restart the list");
   word_append_a: assert property (laterWord ##0 depthQ < SEQ_FULL |=> depthQ == $past(depthQ) + 5'h01)
      else $error("valid word not appended");
   list_full_a: assert property (laterWord ##0 depthQ == SEQ_FULL |=> depthQ == SEQ_FULL)
      else $error("list grew past sixteen words");
   word_skip_a: assert property (sckRise && bitCntQ == WORD_LAST
      && !wordNew[CFG_VALID_BIT] |=> $stable(depthQ))
      else $error("word without valid bit changed the list");
   program_disch_a: assert property (firstWord |=> muxDischarge)
      else $error("summing node discharge missing after programming");
   seq_advance_a: assert property (resultTaken && !wordDone && !lastEntry(seqIdxQ, depthQ)
      |=> seqIdxQ == $past(seqIdxQ) + 4'h1)
      else $error("sequencer did not advance after a result");
   config_track_a: assert property ({gainCompression, inputRange, muxChannel} == curCfg[CFG_W-2:0])
      else $error("configuration outputs differ from current entry");

   // Conversion start and power states
   trial_start_a: assert property (startPulse |=> dacCode == CODE_MSB)
      else $error("search did not begin at half scale");
   result_busy_a: assert property (convS.valid |-> busy)
      else $error("result pending while not busy");
   busy_stall_a: assert property (convS.valid && !convS.ready |=> busy)
      else $error("busy fell while result was waiting");
   wake_edge_a: assert property (cnvEdge |=> !sleepActive)
      else $error("convert edge did not wake the device");
   sleep_enter_a: assert property (slpS && !busy && !cnvEdge |=> sleepActive)
      else $error("idle sleep request not honoured");
   busy_no_sleep_a: assert property (busy && !sleepActive |=> !sleepActive)
      else $error("sleep entered during a conversion");
endmodule
`default_nettype wire

//--- tb/msc_host_model.sv
/*
   Host model: read select, shift clock, serial data in, and the comparator.
   Assumes the same mclk as the device; the shift clock is eight mclk a period.
*/
`timescale 1ns/100ps
`default_nettype none
module msc_host_model import msc_pkg::*; (
   input  wire logic              mclk,
   input  wire logic              sdoOut,
   input  wire logic              sdoOe,
   input  wire logic [CODE_W-1:0] dacCode,
   input  wire logic [CODE_W-1:0] target,
   output logic                   readSelectN,
   output logic                   sck,
   output logic                   sdi,
   output logic                   compIn
);
   initial begin
      readSelectN = 1'b1;
      sck         = 1'b0;
      sdi         = 1'b0;
   end

   // Keeps a trial bit while it stays at or under the sample
   always @(posedge mclk) compIn <= (dacCode <= target);

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Released data line flips so a stale bit is never mistaken for data
   task automatic sel(input logic v);
      readSelectN <= v;
      sdi         <= ~sdi;
   endtask

   // Shift clock with select high, for the gating check
   task automatic pulses(input int n);
      repeat (n) begin
         sck <= 1'b1;
         cyc(4);
         sck <= 1'b0;
         cyc(4);
      end
   endtask

   task automatic frame(input logic [7:0] w[$], output logic [REC_W-1:0] rx, output logic oeOk);
      int nb;
      nb   = (w.size() * 8 > REC_W) ? w.size() * 8 : REC_W;
      rx   = '0;
      oeOk = 1'b1;
      sel(1'b0);
      cyc(6);
      for (int i = 0; i < nb; i++) begin
         sdi <= (i < w.size() * 8) ? w[i / 8][7 - i % 8] : 1'b0; // Set up half a period early
         cyc(4);
         if (i < REC_W) rx[REC_W - 1 - i] = sdoOut;
         oeOk &= (sdoOe === 1'b1);
         sck <= 1'b1;
         cyc(4);
         sck <= 1'b0;
      end
      cyc(4);
      sel(1'b1);
      cyc(6);
   endtask
endmodule
`default_nettype wire

//--- tb/msc_adc_ctrl_tb.sv
/*
   Self-checking bench: conversions, serial frames, sequencer, result FIFO.
   Assumes the host model for select, shift clock, data in and comparator.
*/
`timescale 1ns/100ps
`default_nettype none
module msc_adc_ctrl_tb import msc_pkg::*;;
   logic              mclk, rst, convertStart, sleepReq;
   logic [CODE_W-1:0] target;
   logic              readSelectN, sck, sdi, compIn, sdoOut, sdoOe, busy;
   logic              napActive, sleepActive, muxDischarge, gainCompression, oeOk;
   logic [3:0]        muxChannel;
   logic [1:0]        inputRange;
   logic [CODE_W-1:0] dacCode;
   logic [REC_W-1:0]  rx;
   logic [7:0]        q[$];
   logic [7:0]        ent[$];
   logic [7:0]        w;
   logic [15:0]       tg[5] = '{16'hA5C3, 16'h0001, 16'hFFFF, 16'h8000, 16'h7FFE};
   int                nErrors = 0;
   int                totalChecks = 0;
   int                busyCyc = 0;
   int                discCyc = 0;
   int                d0;

   msc_adc_ctrl DUT (.mclk(mclk), .rst(rst), .convertStart(convertStart), .readSelectN(readSelectN),
      .sck(sck), .sdi(sdi), .sleepReq(sleepReq), .compIn(compIn), .sdoOut(sdoOut), .sdoOe(sdoOe),
      .busy(busy), .napActive(napActive), .sleepActive(sleepActive), .muxDischarge(muxDischarge),
      .gainCompression(gainCompression), .muxChannel(muxChannel), .inputRange(inputRange),
      .dacCode(dacCode));
   msc_host_model host (.mclk(mclk), .sdoOut(sdoOut), .sdoOe(sdoOe), .dacCode(dacCode), .target(target),
      .readSelectN(readSelectN), .sck(sck), .sdi(sdi), .compIn(compIn));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      if (busy === 1'b1) busyCyc <= busyCyc + 1;
      if (muxDischarge === 1'b1) discCyc <= discCyc + 1;
   end

   task automatic stopTest();
      $display("Checks %0d, errors %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [REC_W-1:0] got, input logic [REC_W-1:0] exp, input string what);
      totalChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chkCfg(input logic [7:0] cw);
      chk({gainCompression, inputRange, muxChannel}, cw[6:0], "config");
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic startConv(input logic [CODE_W-1:0] v);
      target       <= v;
      convertStart <= 1'b1;
      for (int t = 0; t < 10 && busy !== 1'b1; t++) cyc(1);
      convertStart <= 1'b0;
   endtask

   // Second edge mid-conversion must neither restart nor stretch busy
   task automatic conv(input logic [CODE_W-1:0] v, input logic glitch);
      int b;
      int d;
      b = busyCyc;
      d = discCyc;
      startConv(v);
      chk(busy, 1'b1, "busy on start");
      if (glitch) begin
         cyc(6);
         convertStart <= 1'b1;
         cyc(6);
         convertStart <= 1'b0;
      end
      for (int t = 0; t < 200 && busy !== 1'b0; t++) cyc(1);
      cyc(1);
      chk(24'(busyCyc - b), 24'd33, "busy length");
      chk(24'(discCyc - d), 24'(MRST_CYC), "discharge");
      chk(dacCode, v, "search result");
   endtask

   initial begin
      #2_000_000;
      nErrors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      stopTest();
   end

   initial begin
      rst          = 1'b1;
      convertStart = 1'b0;
      sleepReq     = 1'b0;
      target       = '0;
      ent          = {8'hD3, 8'hA7, 8'hB1, 8'h82};
      cyc(5);
      chk({sdoOe, busy, napActive, sleepActive, muxDischarge}, 5'b00100, "reset outputs");
      chkCfg(8'h00);
      rst <= 1'b0;
      cyc(2);
      host.sel(1'b0);
      startConv(16'h4321);
      cyc(10);
      chk(sdoOe, 1'b1, "port on");
      rst <= 1'b1;
      cyc(2);
      chk({sdoOe, busy}, 2'b00, "reset mid conversion");
      rst <= 1'b0;
      host.sel(1'b1);
      cyc(4);
      host.pulses(3);
      chk(sdoOe, 1'b0, "released");
      sleepReq <= 1'b1;
      cyc(8);
      chk({sleepActive, napActive}, 2'b10, "sleep");
      sleepReq <= 1'b0;
      conv(16'h1234, 1'b0);
      chk({sleepActive, napActive}, 2'b01, "nap");
      host.frame(q, rx, oeOk);
      chk(rx, {16'h1234, 8'h00}, "first record");
      chk(oeOk, 1'b1, "port enable");
      q  = {8'hD3, 8'h05, 8'hA7, 8'hB1, 8'h82};
      d0 = discCyc;
      host.frame(q, rx, oeOk);
      chk(rx, 24'h0, "abandoned result");
      chk(24'(discCyc - d0), 24'(MRST_CYC), "program discharge");
      chkCfg(8'hD3);
      q = {};
      foreach (tg[k]) begin
         conv(tg[k], k == 1);
         chkCfg(ent[(k + 1) % 4]);
      end
      foreach (tg[k]) begin
         host.frame(q, rx, oeOk);
         w = ent[k % 4];
         chk(rx, {tg[k] ^ {w[4], 15'h0}, w}, "result");
      end
      host.frame(q, rx, oeOk);
      chk(rx, 24'h0, "drained");
      for (int i = 0; i < 17; i++) q.push_back(8'h80 | 8'(i));
      host.frame(q, rx, oeOk);
      chkCfg(8'h80);
      for (int j = 0; j < 32; j++) begin
         conv(16'(j * 977), 1'b0);
         chkCfg(8'h80 | 8'((j + 1) % 16));
      end
      startConv(16'hBEEF);
      cyc(100);
      chk(busy, 1'b1, "stall when full");
      q = {};
      host.frame(q, rx, oeOk);
      chk(rx, {16'h0000, 8'h80}, "oldest record");
      chk(busy, 1'b0, "stall released");
      stopTest();
   end
endmodule
`default_nettype wire
